// ===== verilog/typec_cc_cfg.svh
// constants for the type-c cc attach, role and orientation block
// assumes a 250 MHz ref_clk and straps/cc levels from analog comparators
// Contract
// - after strap latch, address pin becomes connection flag if non-i2c or enabled
// - connection flag high while connected, low otherwise
// - i2c mode: interrupt pulled low at attach, detach or current change, released after a status read
// - non-i2c mode: interrupt pin is audio flag, low for audio accessory
// - non-i2c: current code 00 high, 10 medium, 11 default
// - role indicator low when host sees a valid device partner
// - orientation select low for cc2, high for cc1 or no detection
// - role strap picks host, dual or device; software may override in i2c mode
// - address strap mid: role strap followed at any time
// - address strap mid at latch: pins act as audio flag and current code
// - host current level chosen by register, default after power-up
// - both cc lines watched; device partner or powered cable reported
// - cable-connected bit cleared when nothing is attached
// - interrupt raised at attach, detach and partner current change
// - device role: host current stored in status and shown at pins in non-i2c mode
// - orientation resolved from which cc line carries the partner
// - audio and debug accessories found; termination per cc line reported
// - address strap high gives address 0x7a, low gives 0x3a
// - i2c mode: role strap sampled once; later changes by software
// - mode field 00 device, 01 host, 10 dual; reset from strap
// - current field 00 default, 01 medium, 10 high, 11 reserved
`ifndef TYPEC_CC_CFG_SVH
`define TYPEC_CC_CFG_SVH
`define REF_CLK_PERIOD_PS 4000
`define STRAP_LATCH_NS 10000
`define STRAP_LATCH_CYCLES ((`STRAP_LATCH_NS * 1000 + `REF_CLK_PERIOD_PS - 1) / `REF_CLK_PERIOD_PS)
`define MODE_DEVICE 2'h0
`define MODE_HOST 2'h1
`define MODE_DUAL 2'h2
`define CUR_DEFAULT 2'h0
`define CUR_MEDIUM 2'h1
`define CUR_HIGH 2'h2
`define CUR_RESERVED 2'h3
`define PIN_CUR_HIGH 2'h0
`define PIN_CUR_MEDIUM 2'h2
`define PIN_CUR_DEFAULT 2'h3
`define TERM_OPEN 3'h0
`define TERM_RA 3'h1
`define TERM_RD 3'h2
`define TERM_RP_DEF 3'h3
`define TERM_RP_MED 3'h4
`define TERM_RP_HIGH 3'h5
`define I2C_ADDR_HI 8'h7a
`define I2C_ADDR_LO 8'h3a
`define CON_DIS_RESET 1'h1
`endif

// ===== verilog/typec_cc_pkg.sv
// types shared by the cc detect block and its bench
// assumes typec_cc_cfg.svh for the codes
package typec_cc_pkg;
	typedef enum logic [1:0] {st_strap, st_unattached, st_attached} attach_e;
	typedef struct packed {
		logic attached;
		logic host_att;
		logic dev_att;
		logic cable;
		logic audio;
		logic debug;
		logic orient_cc2;
		logic [1:0] current;
		logic [2:0] cc1_term;
		logic [2:0] cc2_term;
	} status_s;
	typedef struct packed {
		logic out;
		logic oe;
	} pin_s;
endpackage : typec_cc_pkg

// ===== verilog/typec_cc_detect_indicate.sv
// cc attach, role, orientation and accessory logic with strap latch
// assumes comparator codes and strap levels arrive asynchronously
`timescale 1ns/100ps
`include "typec_cc_cfg.svh"
module typec_cc_detect_indicate #(
	parameter int unsigned LATCH_CYCLES = `STRAP_LATCH_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [2:0] cc1_term_raw,
	input wire logic [2:0] cc2_term_raw,
	input wire logic adr_hi_raw,
	input wire logic adr_lo_raw,
	input wire logic role_hi_raw,
	input wire logic role_lo_raw,
	input wire logic mode_wr,
	input wire logic [1:0] mode_wdata,
	input wire logic rp_sel_wr,
	input wire logic [1:0] rp_sel_wdata,
	input wire logic con_dis_wr,
	input wire logic con_dis_wdata,
	input wire logic status_rd,
	output logic strap_done,
	output logic i2c_mode,
	output logic [7:0] i2c_addr,
	output logic [1:0] role_mode,
	output logic [1:0] rp_sel,
	output logic con_dis,
	output typec_cc_pkg::status_s status,
	output logic irq_pending,
	output typec_cc_pkg::pin_s adr_pin,
	output typec_cc_pkg::pin_s irq_pin,
	output typec_cc_pkg::pin_s cur0_pin,
	output typec_cc_pkg::pin_s cur1_pin,
	output typec_cc_pkg::pin_s role_indicator,
	output typec_cc_pkg::pin_s orientation_select
);

	function automatic logic is_rp(input logic [2:0] t);
		is_rp = (t == `TERM_RP_DEF) || (t == `TERM_RP_MED) || (t == `TERM_RP_HIGH);
	endfunction : is_rp

	function automatic logic [1:0] rp_code(input logic [2:0] t);
		case (t)
			`TERM_RP_MED: rp_code = `CUR_MEDIUM;
			`TERM_RP_HIGH: rp_code = `CUR_HIGH;
			default: rp_code = `CUR_DEFAULT;
		endcase
	endfunction : rp_code

	function automatic logic [1:0] strap_role(input logic hi, input logic lo);
		if (hi) begin
			strap_role = `MODE_HOST;
		end else if (lo) begin
			strap_role = `MODE_DEVICE;
		end else begin
			strap_role = `MODE_DUAL;
		end
	endfunction : strap_role

	// two-stage synchronisers; stage one feeds only stage two
	logic [9:0] sync1_reg;
	logic [9:0] sync2_reg;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sync1_reg <= 10'h000;
			sync2_reg <= 10'h000;
		end else begin
			sync1_reg <= {cc1_term_raw, cc2_term_raw, adr_hi_raw, adr_lo_raw,
				role_hi_raw, role_lo_raw};
			sync2_reg <= sync1_reg;
		end
	end
	logic [2:0] cc1_s;
	logic [2:0] cc2_s;
	logic adr_hi_s;
	logic adr_lo_s;
	logic role_hi_s;
	logic role_lo_s;
	assign {cc1_s, cc2_s, adr_hi_s, adr_lo_s, role_hi_s, role_lo_s} = sync2_reg;

	// strap latch timer; the synchroniser delay is small against it
	typec_cc_pkg::attach_e state_reg;
	logic [31:0] timer_reg;
	logic timer_done;
	assign timer_done = (timer_reg >= LATCH_CYCLES - 1);
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			timer_reg <= 32'h0000_0000;
		end else if (state_reg == typec_cc_pkg::st_strap && !timer_done) begin
			timer_reg <= timer_reg + 32'h0000_0001;
		end
	end

	logic latch_now;
	assign latch_now = (state_reg == typec_cc_pkg::st_strap) && timer_done;

	logic i2c_mode_reg;
	logic [7:0] i2c_addr_reg;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			i2c_mode_reg <= 1'h0;
			i2c_addr_reg <= 8'h00;
		end else if (latch_now) begin
			i2c_mode_reg <= adr_hi_s || adr_lo_s;
			i2c_addr_reg <= adr_hi_s ? `I2C_ADDR_HI : `I2C_ADDR_LO;
		end
	end

	// partner detection from the synchronised terminations
	logic [1:0] mode_reg;
	logic host_ok;
	logic dev_ok;
	assign host_ok = (mode_reg == `MODE_HOST) || (mode_reg == `MODE_DUAL);
	assign dev_ok = (mode_reg == `MODE_DEVICE) || (mode_reg == `MODE_DUAL);

	typec_cc_pkg::status_s status_next;
	always_comb begin
		status_next = '0;
		status_next.cc1_term = cc1_s;
		status_next.cc2_term = cc2_s;
		status_next.audio = (cc1_s == `TERM_RA) && (cc2_s == `TERM_RA);
		status_next.debug = ((cc1_s == `TERM_RD) && (cc2_s == `TERM_RD) && host_ok)
			|| (is_rp(cc1_s) && is_rp(cc2_s) && dev_ok);
		status_next.host_att = host_ok && !status_next.debug
			&& ((cc1_s == `TERM_RD) ^ (cc2_s == `TERM_RD));
		status_next.cable = status_next.host_att
			&& ((cc1_s == `TERM_RA) || (cc2_s == `TERM_RA));
		status_next.dev_att = dev_ok && !status_next.debug
			&& !status_next.host_att && (is_rp(cc1_s) ^ is_rp(cc2_s));
		status_next.attached = status_next.host_att || status_next.dev_att
			|| status_next.audio || status_next.debug;
		if (status_next.host_att) begin
			status_next.orient_cc2 = (cc2_s == `TERM_RD);
		end else if (status_next.dev_att) begin
			status_next.orient_cc2 = is_rp(cc2_s);
		end
		if (status_next.dev_att) begin
			status_next.current = status_next.orient_cc2 ? rp_code(cc2_s)
				: rp_code(cc1_s);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_reg <= typec_cc_pkg::st_strap;
		end else begin
			case (state_reg)
				typec_cc_pkg::st_strap: begin
					if (timer_done) begin
						state_reg <= typec_cc_pkg::st_unattached;
					end
				end
				typec_cc_pkg::st_unattached: begin
					if (status_next.attached) begin
						state_reg <= typec_cc_pkg::st_attached;
					end
				end
				typec_cc_pkg::st_attached: begin
					if (!status_next.attached) begin
						state_reg <= typec_cc_pkg::st_unattached;
					end
				end
				default: state_reg <= typec_cc_pkg::st_strap;
			endcase
		end
	end

	logic active;
	assign active = (state_reg != typec_cc_pkg::st_strap);

	typec_cc_pkg::status_s status_reg;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			status_reg <= '0;
		end else if (active) begin
			status_reg <= status_next;
		end
	end

	// mode: strap at latch, then the live strap or software, by i2c mode
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mode_reg <= `MODE_DEVICE;
		end else if (latch_now) begin
			mode_reg <= strap_role(role_hi_s, role_lo_s);
		end else if (active && !i2c_mode_reg) begin
			mode_reg <= strap_role(role_hi_s, role_lo_s);
		end else if (active && mode_wr && mode_wdata != 2'h3) begin
			mode_reg <= mode_wdata;
		end
	end

	// reserved current code is ignored so the source stays valid
	logic [1:0] rp_sel_reg;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rp_sel_reg <= `CUR_DEFAULT;
		end else if (rp_sel_wr && rp_sel_wdata != `CUR_RESERVED) begin
			rp_sel_reg <= rp_sel_wdata;
		end
	end

	logic con_dis_reg;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			con_dis_reg <= `CON_DIS_RESET;
		end else if (con_dis_wr) begin
			con_dis_reg <= con_dis_wdata;
		end
	end

	// set wins over the clear of a read in the same cycle
	logic event_now;
	assign event_now = active && ((status_next.attached != status_reg.attached)
		|| (status_next.current != status_reg.current));
	logic irq_reg;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq_reg <= 1'h0;
		end else if (event_now) begin
			irq_reg <= 1'h1;
		end else if (status_rd) begin
			irq_reg <= 1'h0;
		end
	end

	logic [1:0] pin_cur;
	always_comb begin
		case (status_reg.current)
			`CUR_HIGH: pin_cur = `PIN_CUR_HIGH;
			`CUR_MEDIUM: pin_cur = `PIN_CUR_MEDIUM;
			default: pin_cur = `PIN_CUR_DEFAULT;
		endcase
	end

	// open-drain pins drive low only, high from external pull-ups; adr_pin.out drives the connection flag both ways
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			adr_pin <= '0;
			irq_pin <= '0;
			cur0_pin <= '0;
			cur1_pin <= '0;
			role_indicator <= '0;
			orientation_select <= '0;
		end else begin
			adr_pin.oe <= active && (!i2c_mode_reg || !con_dis_reg);
			adr_pin.out <= status_reg.attached;
			irq_pin.out <= 1'h0;
			irq_pin.oe <= active && (i2c_mode_reg ? irq_reg
				: status_reg.audio);
			cur0_pin.out <= 1'h0;
			cur1_pin.out <= 1'h0;
			cur0_pin.oe <= active && !i2c_mode_reg && !pin_cur[0];
			cur1_pin.oe <= active && !i2c_mode_reg && !pin_cur[1];
			role_indicator.out <= 1'h0;
			role_indicator.oe <= status_reg.host_att;
			orientation_select.out <= 1'h0;
			orientation_select.oe <= status_reg.orient_cc2;
		end
	end

	assign strap_done = active;
	assign i2c_mode = i2c_mode_reg;
	assign i2c_addr = i2c_addr_reg;
	assign role_mode = mode_reg;
	assign rp_sel = rp_sel_reg;
	assign con_dis = con_dis_reg;
	assign status = status_reg;
	assign irq_pending = irq_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	chk_adr_input_early: assert property (!$past(strap_done) |-> !adr_pin.oe)
		else $error("address pin driven before strap latch");
	chk_con_flag_enable: assert property ($rose(strap_done) && !i2c_mode
		|=> adr_pin.oe)
		else $error("connection flag not enabled after latch");
	chk_con_flag_level: assert property (adr_pin.oe
		|-> adr_pin.out == $past(status.attached))
		else $error("connection flag level wrong");
	chk_irq_i2c_only: assert property (i2c_mode && $past(strap_done)
		|-> irq_pin.oe == $past(irq_pending))
		else $error("interrupt pin does not follow pending event");
	chk_audio_flag: assert property (!i2c_mode && $past(strap_done)
		|-> irq_pin.oe == $past(status.audio))
		else $error("audio flag wrong");
	chk_cur_code_high: assert property (!i2c_mode && $past(strap_done)
		&& $past(status.current) == `CUR_HIGH |-> cur0_pin.oe && cur1_pin.oe)
		else $error("high current code wrong");
	chk_cur_code_med: assert property (!i2c_mode && $past(strap_done)
		&& $past(status.current) == `CUR_MEDIUM |-> cur0_pin.oe && !cur1_pin.oe)
		else $error("medium current code wrong");
	chk_event_irq: assert property (strap_done
		&& ($changed(status.attached) || $changed(status.current)) |-> irq_pending)
		else $error("attach or current change without interrupt");
	chk_mode_locked: assert property (i2c_mode && $past(strap_done) && !$past(mode_wr)
		|-> $stable(role_mode))
		else $error("mode changed in i2c mode without a write");
	chk_irq_hold: assert property (irq_pending && !status_rd |=> irq_pending)
		else $error("interrupt dropped before read");
	chk_cable_clear: assert property (!status.attached |-> !status.cable)
		else $error("cable bit set while detached");
	chk_orient_pin: assert property (orientation_select.oe
		|-> $past(status.orient_cc2))
		else $error("orientation select low without cc2");
	chk_role_ind: assert property (status.host_att |=> role_indicator.oe)
		else $error("role indicator not driven");
	chk_rp_default: assert property ($rose(rst_n) |-> rp_sel == `CUR_DEFAULT)
		else $error("host current not default after reset");

	cov_host_attach: cover property (strap_done ##1 status.host_att);
	cov_device_attach: cover property (status.dev_att && status.current == `CUR_HIGH);
	cov_audio: cover property (status.audio && irq_pin.oe);
	cov_irq_clear: cover property (irq_pending ##1 status_rd ##1 !irq_pending);

endmodule : typec_cc_detect_indicate

// ===== dv/cc_partner.sv
// far-end model: the plug's two contacts as seen at cc1 and cc2
// assumes the bench picks the termination of each contact and the plug flip
`timescale 1ns/100ps
module cc_partner (
	input wire logic [2:0] near_term,
	input wire logic [2:0] far_term,
	input wire logic flipped,
	output logic [2:0] cc1_term,
	output logic [2:0] cc2_term
);
	// a flipped plug lands the near contact at cc2
	assign cc1_term = flipped ? far_term : near_term;
	assign cc2_term = flipped ? near_term : far_term;
endmodule : cc_partner

// ===== dv/tb_top.sv
// directed bench for the cc attach, role and orientation block
// assumes cc_partner drives the cc codes; straps and writes come from here
`timescale 1ns/100ps
`include "typec_cc_cfg.svh"
module tb_top;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] near_t = `TERM_OPEN;
	logic [2:0] far_t = `TERM_OPEN;
	logic flip = 1'b0;
	logic [2:0] cc1;
	logic [2:0] cc2;
	logic adr_hi = 1'b0, adr_lo = 1'b0, role_hi = 1'b0, role_lo = 1'b0;
	logic mode_wr = 1'b0, rp_sel_wr = 1'b0, con_dis_wr = 1'b0, con_dis_wdata = 1'b0;
	logic status_rd = 1'b0;
	logic [1:0] mode_wdata = 2'h0;
	logic [1:0] rp_sel_wdata = 2'h0;
	logic strap_done, i2c_mode, con_dis, irq_pending;
	logic [7:0] i2c_addr;
	logic [1:0] role_mode, rp_sel;
	typec_cc_pkg::status_s status;
	typec_cc_pkg::pin_s adr_pin, irq_pin, cur0_pin, cur1_pin, role_indicator, orientation_select;
	logic [2:0] rp_t [3] = '{`TERM_RP_DEF, `TERM_RP_MED, `TERM_RP_HIGH};
	logic [1:0] rp_oe [3] = '{2'h0, 2'h1, 2'h3};
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;

	cc_partner far_end (.near_term(near_t), .far_term(far_t), .flipped(flip),
		.cc1_term(cc1), .cc2_term(cc2));

	typec_cc_detect_indicate #(.LATCH_CYCLES(8)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
		.cc1_term_raw(cc1), .cc2_term_raw(cc2), .adr_hi_raw(adr_hi), .adr_lo_raw(adr_lo),
		.role_hi_raw(role_hi), .role_lo_raw(role_lo), .mode_wr(mode_wr),
		.mode_wdata(mode_wdata), .rp_sel_wr(rp_sel_wr), .rp_sel_wdata(rp_sel_wdata),
		.con_dis_wr(con_dis_wr), .con_dis_wdata(con_dis_wdata), .status_rd(status_rd),
		.strap_done(strap_done), .i2c_mode(i2c_mode), .i2c_addr(i2c_addr),
		.role_mode(role_mode), .rp_sel(rp_sel), .con_dis(con_dis), .status(status),
		.irq_pending(irq_pending), .adr_pin(adr_pin), .irq_pin(irq_pin),
		.cur0_pin(cur0_pin), .cur1_pin(cur1_pin), .role_indicator(role_indicator),
		.orientation_select(orientation_select));

	initial begin
		forever #2 ref_clk = ~ref_clk;
	end

	task print_verdict;
		if (num_errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict

	// the ceiling is about a hundred times the length of the directed sequence
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			print_verdict();
		end
	end

	task step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : step

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	// k: 0 mode, 1 rp select, 2 connection flag disable, 3 status read
	task wr(input int k, input logic [1:0] v);
		mode_wdata = v;
		rp_sel_wdata = v;
		con_dis_wdata = v[0];
		mode_wr = (k == 0);
		rp_sel_wr = (k == 1);
		con_dis_wr = (k == 2);
		status_rd = (k == 3);
		step(1);
		{mode_wr, rp_sel_wr, con_dis_wr, status_rd} = 4'h0;
		step(2);
	endtask : wr

	task boot(input logic ah, input logic al, input logic rh, input logic rl);
		int i;
		{adr_hi, adr_lo, role_hi, role_lo} = {ah, al, rh, rl};
		near_t = `TERM_OPEN;
		far_t = `TERM_OPEN;
		rst_n = 1'b0;
		step(12);
		rst_n = 1'b1;
		step(1);
		chk(16'(adr_pin.oe), 16'h0000);
		for (i = 0; i < 20 && strap_done !== 1'b1; i++) step(1);
		chk(16'(strap_done), 16'h0001);
		step(2);
	endtask : boot

	// status settles three edges after the cc change, pins one edge later
	task plug(input logic [2:0] n, input logic [2:0] f, input logic fl);
		near_t = n;
		far_t = f;
		flip = fl;
		step(6);
	endtask : plug

	initial begin
		int i;
		step(0);
		boot(1'b0, 1'b1, 1'b0, 1'b1);
		chk(16'({i2c_mode, i2c_addr, role_mode}), 16'h04e8);
		boot(1'b1, 1'b0, 1'b1, 1'b0);
		chk(16'({i2c_mode, i2c_addr}), 16'h017a);
		chk(16'(role_mode), 16'(`MODE_HOST));
		chk(16'({rp_sel, con_dis, adr_pin.oe}), 16'h0002);
		wr(2, 2'h0);
		chk(16'({adr_pin.oe, adr_pin.out}), 16'h0002);
		plug(`TERM_RD, `TERM_OPEN, 1'b1);
		chk(16'({status.attached, status.host_att, status.orient_cc2}), 16'h0007);
		chk(16'({role_indicator.oe, orientation_select.oe, adr_pin.out}), 16'h0007);
		chk(16'({irq_pending, irq_pin.oe}), 16'h0003);
		chk(16'({irq_pin.out, cur0_pin.out, cur1_pin.out, role_indicator.out,
			orientation_select.out}), 16'h0000);
		wr(3, 2'h0);
		chk(16'({irq_pending, irq_pin.oe}), 16'h0000);
		plug(`TERM_RD, `TERM_RA, 1'b1);
		chk(16'({status.cable, status.cc1_term, status.cc2_term}), 16'h004a);
		plug(`TERM_OPEN, `TERM_OPEN, 1'b0);
		chk(16'({status.attached, status.cable, adr_pin.out, orientation_select.oe}),
			16'h0000);
		chk(16'(irq_pending), 16'h0001);
		wr(3, 2'h0);
		{role_hi, role_lo} = 2'b01;
		step(6);
		chk(16'(role_mode), 16'(`MODE_HOST));
		wr(0, 2'h3);
		chk(16'(role_mode), 16'(`MODE_HOST));
		wr(0, `MODE_DEVICE);
		chk(16'(role_mode), 16'(`MODE_DEVICE));
		wr(1, `CUR_HIGH);
		wr(1, `CUR_RESERVED);
		chk(16'(rp_sel), 16'(`CUR_HIGH));
		plug(`TERM_RP_HIGH, `TERM_OPEN, 1'b0);
		chk(16'({status.dev_att, status.current, orientation_select.oe, cur0_pin.oe,
			cur1_pin.oe}), 16'h0030);
		wr(3, 2'h0);
		plug(`TERM_RP_MED, `TERM_OPEN, 1'b0);
		chk(16'({status.current, irq_pending, role_indicator.oe}), 16'h0006);

		boot(1'b0, 1'b0, 1'b0, 1'b0);
		chk(16'({i2c_mode, role_mode, adr_pin.oe}), 16'h0005);
		for (i = 0; i < 3; i++) begin
			plug(rp_t[i], `TERM_OPEN, 1'b0);
			chk(16'({cur1_pin.oe, cur0_pin.oe, status.dev_att}), 16'({rp_oe[i], 1'b1}));
		end
		plug(`TERM_RA, `TERM_RA, 1'b0);
		chk(16'({status.audio, irq_pin.oe}), 16'h0003);
		plug(`TERM_RD, `TERM_RD, 1'b0);
		chk(16'({status.debug, status.host_att, irq_pin.oe}), 16'h0004);
		plug(`TERM_RP_DEF, `TERM_RP_DEF, 1'b0);
		chk(16'({status.debug, status.dev_att, cur0_pin.oe, cur1_pin.oe}), 16'h0008);
		plug(`TERM_OPEN, `TERM_OPEN, 1'b0);
		role_hi = 1'b1;
		step(6);
		chk(16'(role_mode), 16'(`MODE_HOST));
		wr(0, `MODE_DEVICE);
		chk(16'(role_mode), 16'(`MODE_HOST));
		plug(`TERM_RD, `TERM_OPEN, 1'b0);
		chk(16'({role_indicator.oe, orientation_select.oe, irq_pin.oe, adr_pin.out}),
			16'h0009);
		print_verdict();
	end
endmodule : tb_top
